// [core/srpmc_core.sv]
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "srpmc_defines.svh"
// Notes on behaviour
// - Chip state bit 0 picks 5-V (default) or 3-V supply setup.
// - Regulator bit 7 high selects automatic, low manual; automatic by default.
// - Automatic: bits 1:0 give 250, 350 or 400 mV drop below input.
// - Manual 5-V: bits 2:0 set PA regulator 4.3-5.0 V; others 3.4 V.
// - Manual 3-V: bits 2:0 set all regulators 2.7-3.4 V together.
// - Automatic default drop 250 mV, capped 5 V PA (3.4 V in 3-V setup) and 3.4 V others.
// - Power state follows main enable, wake pin and chip state bits.
// - Main enable high turns on regulators, oscillator and MCU clock.
// - Enable with state 21/20 gives full power, 31/30 half; wake ignored.
// - Calibration runs on enable rise with bit 7 set and each 0-to-1 of regulator bit 7 while enabled.
// - Chip state bit 5 turns on TX and RX while enabled, unless standby bit 7 is set.
module srpmc_core
  import srpmc_pkg::*;
(
  input wire logic MCU_CLOCK_OUTPUT,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic MAIN_ENABLE_PIN,
  input wire logic WAKE_ENABLE_PIN,
  output logic REG_ENABLE,
  output logic OSC_ENABLE,
  output logic MCU_CLOCK_OUTPUT_EN,
  output logic AUX_CLOCK_EN,
  output logic VDD_X_ENABLE,
  output logic TX_ON,
  output logic RX_ON,
  output logic HALF_POWER,
  output logic SUPPLY_5V,
  output logic AUTO_MODE,
  output logic CAL_BUSY,
  output logic [7:0] DELTA_MV10,
  output logic [7:0] PA_TARGET,
  output logic [7:0] AX_TARGET
);
  // =============================================
  // Register file
  srpmc_byte_t csc_q, csc_d, reg_q, reg_d, rdata_q, rdata_d;
  logic wr_csc, wr_reg;
  assign wr_csc = WR && (ADDR == `SRPMC_ADDR_CSC);
  assign wr_reg = WR && (ADDR == `SRPMC_ADDR_REG);
  assign csc_d = wr_csc ? WDATA : csc_q;
  assign reg_d = wr_reg ? WDATA : reg_q;

  srpmc_state_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic en_q;
  logic [7:0] status;
  assign status = {5'h00, st_q};
  assign rdata_d = !RD ? 8'h00 :
                   (ADDR == `SRPMC_ADDR_CSC) ? csc_q :
                   (ADDR == `SRPMC_ADDR_REG) ? reg_q :
                   (ADDR == `SRPMC_ADDR_STAT) ? status : 8'h00;

  always_ff @(posedge MCU_CLOCK_OUTPUT) begin
    if (!NRST) begin
      csc_q <= `SRPMC_CSC_RST;
      reg_q <= `SRPMC_REG_RST;
      rdata_q <= 8'h00;
    end else begin
      csc_q <= csc_d;
      reg_q <= reg_d;
      rdata_q <= rdata_d;
    end
  end

  // =============================================
  // Calibration sequencer
  logic en_rise, auto_rise;
  assign en_rise = MAIN_ENABLE_PIN && !en_q;
  assign auto_rise = wr_reg && WDATA[`SRPMC_REG_AUTO] && !reg_q[`SRPMC_REG_AUTO];
  logic cal_start;
  assign cal_start = (en_rise && reg_q[`SRPMC_REG_AUTO]) || (MAIN_ENABLE_PIN && auto_rise);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      SRPMC_OFF: begin
        if (MAIN_ENABLE_PIN) begin
          st_d = cal_start ? SRPMC_CAL : SRPMC_RUN;
          cnt_d = `SRPMC_CAL_CYC;
        end
      end
      SRPMC_CAL: begin
        cnt_d = cnt_q - 8'h01;
        if (!MAIN_ENABLE_PIN) begin
          st_d = SRPMC_OFF;
        end else if (cal_start) begin
          cnt_d = `SRPMC_CAL_CYC;
        end else if (cnt_q == 8'h01) begin
          st_d = SRPMC_RUN;
        end
      end
      SRPMC_RUN: begin
        if (!MAIN_ENABLE_PIN) begin
          st_d = SRPMC_OFF;
        end else if (cal_start) begin
          st_d = SRPMC_CAL;
          cnt_d = `SRPMC_CAL_CYC;
        end
      end
    endcase
  end

  always_ff @(posedge MCU_CLOCK_OUTPUT) begin
    if (!NRST) begin
      st_q <= SRPMC_OFF;
      cnt_q <= 8'h00;
      en_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      en_q <= MAIN_ENABLE_PIN;
    end
  end

  // =============================================
  // Target decode
  logic auto_w;
  logic [7:0] delta_w, pa_w, ax_w;
  srpmc_target u_target (
    .reg_ctrl(reg_q),
    .sup5v(csc_q[`SRPMC_CSC_SUP5V]),
    .auto_mode(auto_w),
    .delta(delta_w),
    .pa_tgt(pa_w),
    .ax_tgt(ax_w)
  );

  // =============================================
  // Power mode decode
  logic active, stby, tx_d, rx_d, half_d;
  assign active = MAIN_ENABLE_PIN;
  assign stby = csc_q[`SRPMC_CSC_STBY];
  assign tx_d = active && !stby && csc_q[`SRPMC_CSC_RFON];
  assign rx_d = active && !stby && (csc_q[`SRPMC_CSC_RFON] || csc_q[`SRPMC_CSC_RXON]);
  assign half_d = tx_d && csc_q[`SRPMC_CSC_HALF];

  always_ff @(posedge MCU_CLOCK_OUTPUT) begin
    if (!NRST) begin
      REG_ENABLE <= 1'b0;
      OSC_ENABLE <= 1'b0;
      MCU_CLOCK_OUTPUT_EN <= 1'b0;
      AUX_CLOCK_EN <= 1'b0;
      VDD_X_ENABLE <= 1'b0;
      TX_ON <= 1'b0;
      RX_ON <= 1'b0;
      HALF_POWER <= 1'b0;
      SUPPLY_5V <= 1'b1;
      AUTO_MODE <= 1'b1;
      CAL_BUSY <= 1'b0;
      DELTA_MV10 <= `SRPMC_DELTA_250;
      PA_TARGET <= `SRPMC_V_5P0;
      AX_TARGET <= `SRPMC_V_3P4;
    end else begin
      REG_ENABLE <= active;
      OSC_ENABLE <= active;
      MCU_CLOCK_OUTPUT_EN <= active;
      // Wake pin keeps aux clock and VDD_X while main enable is low
      AUX_CLOCK_EN <= !active && WAKE_ENABLE_PIN;
      VDD_X_ENABLE <= active || WAKE_ENABLE_PIN;
      TX_ON <= tx_d;
      RX_ON <= rx_d;
      HALF_POWER <= half_d;
      SUPPLY_5V <= csc_q[`SRPMC_CSC_SUP5V];
      AUTO_MODE <= auto_w;
      CAL_BUSY <= (st_d == SRPMC_CAL);
      DELTA_MV10 <= delta_w;
      PA_TARGET <= pa_w;
      AX_TARGET <= ax_w;
    end
  end
  assign RDATA = rdata_q;

  // =============================================
  // Assertions
  a_supply_select: assert property (@(posedge MCU_CLOCK_OUTPUT) disable iff (!NRST)
    wr_csc |=> ##1 (SUPPLY_5V == $past(WDATA[0], 2)))
    else $error("supply select wrong");
  a_auto_mode: assert property (@(posedge MCU_CLOCK_OUTPUT) disable iff (!NRST)
    wr_reg |=> ##1 (AUTO_MODE == $past(WDATA[7], 2)))
    else $error("auto mode wrong");
  a_delta_250: assert property (@(posedge MCU_CLOCK_OUTPUT) disable iff (!NRST)
    (reg_q[1:0] == 2'h3) |=> (DELTA_MV10 == 8'd25))
    else $error("delta wrong");
  a_manual_5v: assert property (@(posedge MCU_CLOCK_OUTPUT) disable iff (!NRST)
    (!reg_q[7] && csc_q[0]) |=> (PA_TARGET == 8'd43 + {5'h00, $past(reg_q[2:0])}
      && AX_TARGET == 8'd34))
    else $error("manual 5v target wrong");
  a_manual_3v: assert property (@(posedge MCU_CLOCK_OUTPUT) disable iff (!NRST)
    (!reg_q[7] && !csc_q[0]) |=> (PA_TARGET == AX_TARGET
      && AX_TARGET == 8'd27 + {5'h00, $past(reg_q[2:0])}))
    else $error("manual 3v target wrong");
  a_enable_on: assert property (@(posedge MCU_CLOCK_OUTPUT) disable iff (!NRST)
    MAIN_ENABLE_PIN |=> (REG_ENABLE && OSC_ENABLE && MCU_CLOCK_OUTPUT_EN && !AUX_CLOCK_EN))
    else $error("enable outputs wrong");
  a_half_power: assert property (@(posedge MCU_CLOCK_OUTPUT) disable iff (!NRST)
    (MAIN_ENABLE_PIN && csc_q[7:1] == 7'h18) |=> (TX_ON && RX_ON && HALF_POWER))
    else $error("half power wrong");
  sequence s_auto_rise;
    MAIN_ENABLE_PIN && auto_rise;
  endsequence
  a_cal_start: assert property (@(posedge MCU_CLOCK_OUTPUT) disable iff (!NRST)
    s_auto_rise ##1 MAIN_ENABLE_PIN |-> CAL_BUSY)
    else $error("calibration not started");
  a_rf_off: assert property (@(posedge MCU_CLOCK_OUTPUT) disable iff (!NRST)
    !csc_q[5] |=> !TX_ON)
    else $error("tx without rf bit");
endmodule // srpmc_core

// [inc/srpmc_defines.svh]
`ifndef SRPMC_DEFINES_SVH
`define SRPMC_DEFINES_SVH
// Register offsets
`define SRPMC_ADDR_CSC 8'h00
`define SRPMC_ADDR_REG 8'h0b
`define SRPMC_ADDR_STAT 8'h0c
// Reset values
`define SRPMC_CSC_RST 8'h01
`define SRPMC_REG_RST 8'h87
// Chip state control fields
`define SRPMC_CSC_SUP5V 0
`define SRPMC_CSC_RXON 1
`define SRPMC_CSC_HALF 4
`define SRPMC_CSC_RFON 5
`define SRPMC_CSC_STBY 7
// Regulator control fields
`define SRPMC_REG_AUTO 7
// Target codes in 100 mV units (tens of mV for delta)
`define SRPMC_DELTA_250 8'd25
`define SRPMC_DELTA_350 8'd35
`define SRPMC_DELTA_400 8'd40
`define SRPMC_V_4P3 8'd43
`define SRPMC_V_2P7 8'd27
`define SRPMC_V_3P4 8'd34
`define SRPMC_V_5P0 8'd50
// Calibration length in cycles
`define SRPMC_CAL_CYC 8'd16
`endif

// [inc/srpmc_pkg.sv]
package srpmc_pkg;
  typedef logic [7:0] srpmc_byte_t;
  typedef enum logic [2:0] {
    SRPMC_OFF = 3'b001,
    SRPMC_CAL = 3'b010,
    SRPMC_RUN = 3'b100
  } srpmc_state_e;
endpackage

// [core/srpmc_target.sv]
`timescale 1ns/10ps
`include "srpmc_defines.svh"
// =============================================
// Regulator target decode
module srpmc_target
  import srpmc_pkg::*;
(
  input wire logic [7:0] reg_ctrl,
  input wire logic sup5v,
  output logic auto_mode,
  output logic [7:0] delta,
  output logic [7:0] pa_tgt,
  output logic [7:0] ax_tgt
);
  logic [7:0] step;
  assign step = {5'h00, reg_ctrl[2:0]};
  assign auto_mode = reg_ctrl[`SRPMC_REG_AUTO];
  // Delta from bits 1:0; 01 treated as 400 mV
  assign delta = (reg_ctrl[1:0] == 2'h3) ? `SRPMC_DELTA_250 :
                 (reg_ctrl[1:0] == 2'h2) ? `SRPMC_DELTA_350 : `SRPMC_DELTA_400;
  assign pa_tgt = auto_mode ? (sup5v ? `SRPMC_V_5P0 : `SRPMC_V_3P4) :
                  sup5v ? (`SRPMC_V_4P3 + step) : (`SRPMC_V_2P7 + step);
  assign ax_tgt = (auto_mode || sup5v) ? `SRPMC_V_3P4 : (`SRPMC_V_2P7 + step);
endmodule // srpmc_target

// [test/tb_supply_regulator_power_mode_ctrl.sv]
`timescale 1ns/10ps
`include "srpmc_defines.svh"
// ====
// Bench
module tb_supply_regulator_power_mode_ctrl
  import srpmc_pkg::*;
;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, men = 0, wk = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat, dl, pa, ax, rv, c, r;
  logic ren, osc, mcu, aux, vx, tx, rx, hp, s5, am, cb;
  int n_fail = 0, checks_done = 0, seed = 32'h46e4, n;
  logic [7:0] md [9] = '{8'h21, 8'h20, 8'h31, 8'h30, 8'h81, 8'h03, 8'h01, 8'h00, 8'h02};
  srpmc_core srpmc_core_i (.MCU_CLOCK_OUTPUT(clk), .NRST(nrst), .ADDR(addr), .WDATA(wd), .WR(wr),
    .RD(rd), .RDATA(rdat), .MAIN_ENABLE_PIN(men), .WAKE_ENABLE_PIN(wk), .REG_ENABLE(ren),
    .OSC_ENABLE(osc), .MCU_CLOCK_OUTPUT_EN(mcu), .AUX_CLOCK_EN(aux), .VDD_X_ENABLE(vx),
    .TX_ON(tx), .RX_ON(rx), .HALF_POWER(hp), .SUPPLY_5V(s5), .AUTO_MODE(am), .CAL_BUSY(cb),
    .DELTA_MV10(dl), .PA_TARGET(pa), .AX_TARGET(ax));
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdat;
  endtask
  function logic [7:0] e_pa(input logic [7:0] g, input logic f);
    if (g[7]) return f ? `SRPMC_V_5P0 : `SRPMC_V_3P4;
    return (f ? `SRPMC_V_4P3 : `SRPMC_V_2P7) + {5'h00, g[2:0]};
  endfunction
  function logic [7:0] e_ax(input logic [7:0] g, input logic f);
    if (g[7] || f) return `SRPMC_V_3P4;
    return `SRPMC_V_2P7 + {5'h00, g[2:0]};
  endfunction
  function logic [7:0] e_dl(input logic [1:0] b);
    return b == 2'h3 ? `SRPMC_DELTA_250 : b == 2'h2 ? `SRPMC_DELTA_350 : `SRPMC_DELTA_400;
  endfunction
  task cfg(input logic [7:0] cv, rg);
    wr_reg(`SRPMC_ADDR_CSC, cv);
    wr_reg(`SRPMC_ADDR_REG, rg);
    repeat (3) @(posedge clk);
    #1 chk("supply", {7'h00, s5}, {7'h00, cv[0]});
    chk("auto", {7'h00, am}, {7'h00, rg[7]});
    chk("pa", pa, e_pa(rg, cv[0]));
    chk("ax", ax, e_ax(rg, cv[0]));
    if (rg[7]) chk("delta", dl, e_dl(rg[1:0]));
    rd_reg(`SRPMC_ADDR_REG);
    chk("reg read", rv, rg);
  endtask
  task pwr(input logic [7:0] cv, input logic m, w);
    logic t;
    t = m && !cv[7] && cv[5];
    @(posedge clk);
    men <= m;
    wk <= w;
    wr_reg(`SRPMC_ADDR_CSC, cv);
    repeat (3) @(posedge clk);
    #1 chk("power", {tx, rx, hp, ren, osc, mcu, aux, vx}, {t, m && !cv[7] && (cv[5] || cv[1]),
      t && cv[4], m, m, m, !m && w, m || w});
  endtask
  task cal_len;
    int k;
    k = 0;
    n = 0;
    #1;
    while (!cb && k < 4) begin
      @(posedge clk);
      #1 k++;
    end
    while (cb && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk("cal cycles", n[7:0], `SRPMC_CAL_CYC);
  endtask
  // ====
  // Sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(`SRPMC_ADDR_CSC);
    chk("csc reset", rv, `SRPMC_CSC_RST);
    rd_reg(`SRPMC_ADDR_REG);
    chk("reg reset", rv, `SRPMC_REG_RST);
    chk("reset delta", dl, `SRPMC_DELTA_250);
    chk("reset pa", pa, `SRPMC_V_5P0);
    chk("reset ax", ax, `SRPMC_V_3P4);
    chk("reset en", {7'h00, ren}, 8'h00);
    $display("test reset done");
    foreach (md[i]) pwr(md[i], 1'b1, 1'($random(seed)));
    pwr(8'h21, 1'b0, 1'b1);
    pwr(8'h21, 1'b0, 1'b0);
    $display("test power modes done");
    for (int i = 0; i < 8; i++) begin
      cfg(8'h01, 8'(i));
      cfg(8'h00, 8'(i));
      r = 8'($random(seed));
      cfg({7'h00, r[0]}, {1'b1, r[6:2], i[1] | i[2], i[0] | i[2]});
    end
    repeat (16) begin
      c = 8'($random(seed));
      r = 8'($random(seed));
      cfg(c, r);
    end
    $display("test regulator decode done");
    wr_reg(8'h55, 8'hff);
    rd_reg(8'h55);
    chk("unmapped", rv, 8'h00);
    rd_reg(`SRPMC_ADDR_CSC);
    chk("csc kept", rv, c);
    $display("test unmapped done");
    pwr(8'h21, 1'b0, 1'b0);
    wr_reg(`SRPMC_ADDR_REG, 8'h87);
    @(posedge clk);
    men <= 1'b1;
    cal_len;
    wr_reg(`SRPMC_ADDR_REG, 8'h07);
    wr_reg(`SRPMC_ADDR_REG, 8'h87);
    cal_len;
    wr_reg(`SRPMC_ADDR_REG, 8'h87);
    repeat (4) @(posedge clk);
    #1 chk("no recal", {7'h00, cb}, 8'h00);
    rd_reg(`SRPMC_ADDR_STAT);
    chk("status run", rv, 8'h04);
    wr_reg(`SRPMC_ADDR_REG, 8'h07);
    wr_reg(`SRPMC_ADDR_REG, 8'h87);
    men <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("cal abort", {7'h00, cb}, 8'h00);
    $display("test calibration done");
    stop_test;
  end
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
endmodule // tb_supply_regulator_power_mode_ctrl
